// [verilog/adc_ctl_pkg.sv]
// Constants and types for the converter start control block
package adc_ctl_pkg;
  localparam logic [11:0] ADDR_CONTROL_0   = 12'h000;
  localparam logic [11:0] ADDR_ACQ_CONFIG  = 12'h004;
  localparam logic [11:0] ADDR_RESULT      = 12'h008;
  localparam logic [11:0] ADDR_STATUS      = 12'h00c;

  localparam int SEL_LSB = 2;
  localparam int SEL_W   = 4;
  localparam int GO_BIT  = 1;
  localparam int EN_BIT  = 0;
  localparam int RES_W   = 10;
  localparam int ACQ_W   = 3;

  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_IMPL     = 8'h3f;
  localparam logic [3:0]  SEL_FIRST_EXT = 4'h3;
  localparam logic [3:0]  SEL_LAST_EXT  = 4'hb;
  localparam logic [3:0]  SEL_DAC       = 4'he;
  localparam logic [3:0]  SEL_REF       = 4'hf;

  // Conversion clock period in ns and cycles of MCLK
  localparam int CLK_NS        = 5;
  localparam int PERIOD_NS     = 1000;
  localparam int PERIOD_CYC    = (PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int PERIOD_CNT_W  = 8;
  localparam int WAIT_PERIODS  = 2;
  localparam logic [7:0] PERIOD_LAST = 8'(PERIOD_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10,
    ST_WAIT = 2'b11
  } conv_state_t;

  typedef struct packed {
    logic [SEL_W-1:0] channel;
    logic             connect;
    logic             sample;
    logic             power;
  } mux_ctl_t;
endpackage

// [verilog/sar_stepper.sv]
// Successive approximation stepper: one result bit per conversion clock period
`timescale 1ns/10ps
module sar_stepper
  import adc_ctl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             comp,
  output logic                  busy,
  output logic                  done,
  output logic [RES_W-1:0]      result
);
  logic [RES_W-1:0] bits_q, bits_d;
  logic [3:0]       idx_q, idx_d;
  logic             busy_q, busy_d;
  logic             done_q, done_d;
  logic [RES_W-1:0] res_q, res_d;

  always_comb
  begin
    bits_d = bits_q;
    idx_d  = idx_q;
    busy_d = busy_q;
    done_d = 1'b0;
    res_d  = res_q;
    if (start)
    begin
      busy_d = 1'b1;
      idx_d  = 4'(RES_W - 1);
      bits_d = '0;
    end
    else if (busy_q && abort)
    begin
      busy_d = 1'b0;
      done_d = 1'b1;
      // Unconverted bits copy the last converted bit
      for (int i = 0; i < RES_W; i++)
        if (i <= int'(idx_q))
          res_d[i] = (idx_q == 4'(RES_W - 1)) ? 1'b0 : bits_q[idx_q + 4'h1];
        else
          res_d[i] = bits_q[i];
    end
    else if (busy_q && tick)
    begin
      bits_d[idx_q] = comp;
      if (idx_q == 4'h0)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        res_d  = {bits_q[RES_W-1:1], comp};
      end
      else
        idx_d = idx_q - 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bits_q <= '0;
      idx_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      res_q  <= '0;
    end
    else
    begin
      bits_q <= bits_d;
      idx_q  <= idx_d;
      busy_q <= busy_d;
      done_q <= done_d;
      res_q  <= res_d;
    end
  end

  assign busy   = busy_q;
  assign done   = done_q;
  assign result = res_q;
endmodule

// [verilog/adc_channel_start_control.sv]
// Converter control register, sequencer and APB slave
`timescale 1ns/10ps
module adc_channel_start_control
  import adc_ctl_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        COMP_IN,
  output mux_ctl_t         MUX_CTL
);
  logic [5:0]       ctrl_q, ctrl_d;
  logic [ACQ_W-1:0] acq_q, acq_d;
  logic [RES_W-1:0] result_q, result_d;
  logic             flag_q, flag_d;
  conv_state_t      st_q, st_d;
  logic [PERIOD_CNT_W-1:0] div_q, div_d;
  logic             tick;
  logic [4:0]       per_q, per_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;
  mux_ctl_t         mux_q, mux_d;
  logic             comp_s1_q, comp_s2_q;
  logic             sar_start, sar_abort, sar_busy, sar_done;
  logic [RES_W-1:0] sar_result;
  logic             access, wr_ctrl, go_wr, go_clr;

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == ADDR_CONTROL_0) || (a == ADDR_ACQ_CONFIG) ||
                 (a == ADDR_RESULT) || (a == ADDR_STATUS);
  endfunction

  // Acquisition length in conversion clock periods
  function automatic logic [4:0] acq_periods(input logic [ACQ_W-1:0] s);
    unique case (s)
      3'h0: acq_periods = 5'h00;
      3'h1: acq_periods = 5'h02;
      3'h2: acq_periods = 5'h04;
      3'h3: acq_periods = 5'h06;
      3'h4: acq_periods = 5'h08;
      3'h5: acq_periods = 5'h0c;
      3'h6: acq_periods = 5'h10;
      3'h7: acq_periods = 5'h14;
    endcase
  endfunction

  assign access  = PSEL && PENABLE && pready_q;
  assign wr_ctrl = access && PWRITE && (PADDR == ADDR_CONTROL_0);
  assign go_wr   = wr_ctrl && PWDATA[GO_BIT] && PWDATA[EN_BIT];
  assign go_clr  = wr_ctrl && !PWDATA[GO_BIT];

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end
    else
    begin
      comp_s1_q <= COMP_IN;
      comp_s2_q <= comp_s1_q;
    end
  end

  // Conversion clock enable divider; restarts on each state change so waits span whole periods
  always_comb
  begin
    tick  = (div_q == PERIOD_LAST);
    div_d = (tick || (st_d != st_q)) ? '0 : div_q + 8'h01;
  end

  // Sequencer and control bits
  always_comb
  begin
    st_d      = st_q;
    per_d     = per_q;
    ctrl_d    = ctrl_q;
    flag_d    = flag_q;
    result_d  = result_q;
    acq_d     = acq_q;
    sar_start = 1'b0;
    sar_abort = 1'b0;
    if (access && PWRITE && (PADDR == ADDR_ACQ_CONFIG))
      acq_d = PWDATA[ACQ_W-1:0];
    if (access && PWRITE && (PADDR == ADDR_STATUS) && PWDATA[0])
      flag_d = 1'b0;
    if (wr_ctrl)
    begin
      ctrl_d[SEL_LSB+SEL_W-1:SEL_LSB] = PWDATA[SEL_LSB+SEL_W-1:SEL_LSB];
      ctrl_d[EN_BIT] = PWDATA[EN_BIT];
    end
    unique case (st_q)
      ST_IDLE:
      begin
        if (go_wr)
        begin
          ctrl_d[GO_BIT] = 1'b1;
          per_d = acq_periods(acq_q);
          if (acq_periods(acq_q) == 5'h00)
          begin
            st_d = ST_CONV;
            sar_start = 1'b1;
          end
          else
            st_d = ST_ACQ;
        end
      end
      ST_ACQ:
      begin
        if (go_clr || (wr_ctrl && !PWDATA[EN_BIT]))
        begin
          ctrl_d[GO_BIT] = 1'b0;
          st_d = ST_WAIT;
          per_d = 5'(WAIT_PERIODS);
        end
        else if (tick)
        begin
          if (per_q == 5'h01)
          begin
            st_d = ST_CONV;
            sar_start = 1'b1;
          end
          per_d = per_q - 5'h01;
        end
      end
      ST_CONV:
      begin
        if (go_clr || (wr_ctrl && !PWDATA[EN_BIT]))
          sar_abort = 1'b1;
        if (sar_done)
        begin
          ctrl_d[GO_BIT] = 1'b0;
          flag_d = 1'b1;
          result_d = sar_result;
          st_d = ST_WAIT;
          per_d = 5'(WAIT_PERIODS);
        end
        else if (sar_abort)
          ctrl_d[GO_BIT] = 1'b0;
      end
      ST_WAIT:
      begin
        if (tick)
        begin
          per_d = per_q - 5'h01;
          if (per_q == 5'h01)
            st_d = ST_IDLE;
        end
      end
    endcase
  end

  // Mux control toward the analog core
  always_comb
  begin
    mux_d.channel = ctrl_q[SEL_LSB+SEL_W-1:SEL_LSB];
    mux_d.power   = ctrl_q[EN_BIT];
    mux_d.connect = ctrl_q[EN_BIT] && (st_q != ST_WAIT) && (st_q != ST_CONV);
    mux_d.sample  = (st_q == ST_CONV);
  end

  // APB read path, zero wait states
  always_comb
  begin
    prdata_d  = prdata_q;
    pready_d  = 1'b1;
    pslverr_d = 1'b0;
    if (PSEL && !PENABLE && !PWRITE)
    begin
      unique case (PADDR)
        ADDR_CONTROL_0:  prdata_d = {24'h000000, 2'b00, ctrl_q} & {24'h000000, CTRL_IMPL};
        ADDR_ACQ_CONFIG: prdata_d = {29'h0, acq_q};
        ADDR_RESULT:     prdata_d = {22'h0, result_q};
        ADDR_STATUS:     prdata_d = {29'h0, st_q == ST_CONV, st_q != ST_IDLE, flag_q};
        default:         prdata_d = 32'h00000000;
      endcase
    end
    if (PSEL && !PENABLE)
      pslverr_d = !known_addr(PADDR);
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      ctrl_q    <= CTRL_RESET[5:0];
      acq_q     <= '0;
      result_q  <= '0;
      flag_q    <= 1'b0;
      st_q      <= ST_IDLE;
      div_q     <= '0;
      per_q     <= '0;
      prdata_q  <= '0;
      pready_q  <= 1'b1;
      pslverr_q <= 1'b0;
      mux_q     <= '0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      acq_q     <= acq_d;
      result_q  <= result_d;
      flag_q    <= flag_d;
      st_q      <= st_d;
      div_q     <= div_d;
      per_q     <= per_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      mux_q     <= mux_d;
    end
  end

  sar_stepper u_sar (
    .clk    (MCLK),
    .rst_n  (RESETN),
    .tick   (tick),
    .start  (sar_start),
    .abort  (sar_abort),
    .comp   (comp_s2_q),
    .busy   (sar_busy),
    .done   (sar_done),
    .result (sar_result)
  );

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign MUX_CTL = mux_q;

  property p_go_needs_enable;
    @(posedge MCLK) disable iff (!RESETN)
    (st_q == ST_IDLE && wr_ctrl && PWDATA[GO_BIT] && !PWDATA[EN_BIT]) |=> !ctrl_q[GO_BIT];
  endproperty
  a_go_needs_enable: assert property (p_go_needs_enable) else $error("start without enable");

  property p_go_while_busy;
    @(posedge MCLK) disable iff (!RESETN)
    sar_busy |-> ctrl_q[GO_BIT] || sar_abort;
  endproperty
  a_go_while_busy: assert property (p_go_while_busy) else $error("start bit low while converting");

  property p_done_clears;
    @(posedge MCLK) disable iff (!RESETN)
    (st_q == ST_CONV && sar_done) |=> !ctrl_q[GO_BIT] && flag_q && result_q == $past(sar_result);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("completion effects missing");

  property p_wait_no_connect;
    @(posedge MCLK) disable iff (!RESETN)
    (st_q == ST_WAIT) |=> !MUX_CTL.connect;
  endproperty
  a_wait_no_connect: assert property (p_wait_no_connect) else $error("channel reconnected early");

  property p_top_bits_zero;
    @(posedge MCLK) disable iff (!RESETN)
    $past(PSEL && !PENABLE && !PWRITE && PADDR == ADDR_CONTROL_0) |-> PRDATA[7:6] == 2'b00;
  endproperty
  a_top_bits_zero: assert property (p_top_bits_zero) else $error("unimplemented bits nonzero");

  property p_enable_power;
    @(posedge MCLK) disable iff (!RESETN)
    ##1 MUX_CTL.power == $past(ctrl_q[EN_BIT]);
  endproperty
  a_enable_power: assert property (p_enable_power) else $error("power not following enable");

  property p_start_go;
    @(posedge MCLK) disable iff (!RESETN)
    (st_q == ST_IDLE && go_wr) |=> ctrl_q[GO_BIT] && st_q != ST_IDLE;
  endproperty
  a_start_go: assert property (p_start_go) else $error("start not taken");

  property p_zero_acq;
    @(posedge MCLK) disable iff (!RESETN)
    (st_q == ST_IDLE && go_wr && acq_q == 3'h0) |=> st_q == ST_CONV;
  endproperty
  a_zero_acq: assert property (p_zero_acq) else $error("zero acquisition not immediate");

  property p_abort;
    @(posedge MCLK) disable iff (!RESETN)
    (st_q == ST_CONV && sar_abort) |=> !ctrl_q[GO_BIT] ##1 st_q == ST_WAIT;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not handled");
endmodule

// [test/analog_core_model.sv]
// Behavioural comparator front end of the analog core
`timescale 1ns/10ps
module analog_core_model
  import adc_ctl_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     level,
  input  wire mux_ctl_t mux,
  output logic          comp
);
  logic flip_q = 1'b0;
  logic routed;

  // Reserved codes and a powered-down core leave the input floating
  assign routed = mux.power && ((mux.channel >= SEL_FIRST_EXT && mux.channel <= SEL_LAST_EXT)
                                || mux.channel >= SEL_DAC);
  always @(posedge clk) flip_q <= ~flip_q;
  assign comp = routed ? level : flip_q;
endmodule

// [test/adc_channel_start_control_tb.sv]
// Self-checking bench for the converter start control block
`timescale 1ns/10ps
module adc_channel_start_control_tb;
  import adc_ctl_pkg::*;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} note_t;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        comp;
  logic        level = 1'b1;
  mux_ctl_t    mux_ctl;
  logic [31:0] rdata;
  logic [3:0]  ch;
  note_t       notes[$];
  note_t       nt;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n;
  int          seed;

  adc_channel_start_control i_adc_channel_start_control (.MCLK(mclk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .COMP_IN(comp), .MUX_CTL(mux_ctl));
  analog_core_model i_analog_core_model (.clk(mclk), .level(level), .mux(mux_ctl), .comp(comp));

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic fail(input string msg);
    miscompares++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) fail(msg);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input note_t e);
    notes.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic er = 1'b0);
    apb(1'b1, a, d, '{32'h0, 32'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1, input logic er = 1'b0);
    apb(1'b0, a, 32'h0, '{e, m, er});
  endtask

  // Oldest note is compared at every completed transfer
  always @(posedge mclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      cmp_count++;
      if (notes.size() == 0) fail("transfer without note");
      else
      begin
        nt = notes.pop_front();
        if ((prdata & nt.mask) !== (nt.data & nt.mask) || pslverr !== nt.err) fail("bus result mismatch");
      end
    end
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail("timeout");
      wrap_up();
    end
  end

  initial
  begin
    seed = 32'ha7fd2656;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(ADDR_CONTROL_0, 32'h0);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    wr(ADDR_CONTROL_0, 32'hfe);
    rd(ADDR_CONTROL_0, 32'h3c);
    chk(32'(mux_ctl.power), 32'h0, "power while disabled");
    wr(12'h010, 32'h1, 1'b1);
    rd(12'h010, 32'h0, '1, 1'b1);
    for (int c = 3; c < 16; c++)
    begin
      if (c < 12 || c > 13)
      begin
        wr(ADDR_CONTROL_0, 32'({4'(c), 2'b01}));
        rd(ADDR_CONTROL_0, 32'({4'(c), 2'b01}));
        chk(32'(mux_ctl.channel), 32'(c), "channel route");
        chk(32'(mux_ctl.power), 32'h1, "power on");
      end
    end
    // Full conversion on a random input and level
    level <= 1'($random(seed));
    ch = 4'(3 + {$random(seed)} % 9);
    wr(ADDR_ACQ_CONFIG, 32'h0);
    wr(ADDR_CONTROL_0, 32'({ch, 2'b11}));
    rd(ADDR_CONTROL_0, 32'({ch, 2'b11}));
    rd(ADDR_STATUS, 32'h6, 32'h6);
    rdata = 32'h0;
    while (rdata[0] !== 1'b1) rd(ADDR_STATUS, 32'h0, 32'h0);
    rd(ADDR_CONTROL_0, 32'({ch, 2'b01}));
    rd(ADDR_RESULT, 32'({10{level}}));
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    level <= 1'b1;
    repeat (450) @(posedge mclk);
    for (int k = 0; k < 3; k++)
    begin
      wr(ADDR_ACQ_CONFIG, 32'(k));
      wr(ADDR_CONTROL_0, 32'({ch, 2'b11}));
      for (n = 0; n < 2000 && mux_ctl.sample !== 1'b1; n++) @(posedge mclk);
      chk(32'(n >= 2 * k * PERIOD_CYC - 5 && n <= 2 * k * PERIOD_CYC + 10), 32'h1, "acquisition delay");
      repeat (500) @(posedge mclk);
      wr(ADDR_CONTROL_0, 32'({ch, 2'b01}));
      wr(ADDR_CONTROL_0, 32'({ch, 2'b11}));
      for (n = 0; n < 1000 && mux_ctl.connect !== 1'b1; n++) @(posedge mclk);
      chk(32'(n >= WAIT_PERIODS * PERIOD_CYC - 15 && n <= WAIT_PERIODS * PERIOD_CYC + 5), 32'h1, "reconnect wait");
      rd(ADDR_CONTROL_0, 32'({ch, 2'b01}));
      rd(ADDR_RESULT, 32'h3ff);
    end
    wrap_up();
  end
endmodule
